// ---- adc_result_format_and_acquire.v ----
// converter control: registers on avalon-mm, acquisition delay, conversion sequencing, result formatting
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`include "adc_result_map.vh"
module adc_result_format_and_acquire #(
  parameter bit_period = `BIT_PERIOD_CYCLES,
  parameter rc_bit_period = `RC_BIT_PERIOD_CYCLES,
  parameter instr_cycles = `INSTR_CYCLES
) (
  input wire ref_clk,
  input wire srst,
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  output reg irq,
  output reg [3:0] input_channel_select,
  output reg [1:0] reference_source_select,
  output reg sample_enable,
  input wire [9:0] conversion_result
);
  localparam st_idle = 3'h0;
  localparam st_rc_wait = 3'h1;
  localparam st_acquire = 3'h2;
  localparam st_convert = 3'h3;

  reg [2:0] state;
  reg converter_power_on;
  reg go;
  reg result_justify_select;
  reg [2:0] acquisition_delay_select;
  reg [2:0] conversion_clock_select;
  reg [7:0] result_high_byte;
  reg [7:0] result_low_byte;
  reg conversion_done_irq_flag;
  reg irq_mask;
  reg [15:0] tick_cnt;
  reg [5:0] period_cnt;
  reg bus_done;
  reg [5:0] acq_periods;
  reg [15:0] bit_len;
  wire rc_clock;
  wire bit_tick;
  wire access;
  wire finish;
  wire wr_ctl0;
  wire [9:0] code;

  assign rc_clock = conversion_clock_select[1] & conversion_clock_select[0];
  assign access = (read | write) & waitrequest & ~bus_done;
  assign wr_ctl0 = access & write & (address == {1'b0, `OFS_CONTROL_ZERO});
  assign bit_tick = (tick_cnt == bit_len - 16'h0001);
  assign finish = (state == st_convert) & bit_tick & (period_cnt == 6'd`CONV_BITS - 6'd1);
  assign code = conversion_result;

  always @* begin
    case (acquisition_delay_select)
      3'h0: acq_periods = 6'd0;
      3'h1: acq_periods = 6'd2;
      3'h2: acq_periods = 6'd4;
      3'h3: acq_periods = 6'd6;
      3'h4: acq_periods = 6'd8;
      3'h5: acq_periods = 6'd12;
      3'h6: acq_periods = 6'd16;
      default: acq_periods = 6'd20;
    endcase
    bit_len = rc_clock ? rc_bit_period[15:0] : bit_period[15:0];
  end

  // sequencer; leaving power off aborts a conversion
  always @(posedge ref_clk) begin
    if (srst) begin
      state <= st_idle;
      go <= 1'b0;
      tick_cnt <= 16'h0000;
      period_cnt <= 6'd0;
      sample_enable <= 1'b0;
    end else begin
      tick_cnt <= (state == st_idle || bit_tick) ? 16'h0000 : tick_cnt + 16'h0001;
      case (state)
        st_idle: begin
          period_cnt <= 6'd0;
          if (wr_ctl0 && writedata[`BIT_GO] && converter_power_on) begin
            go <= 1'b1;
            sample_enable <= 1'b1;
            // a zero acquisition code must not leave a stray sampling cycle behind
            if (rc_clock) begin
              state <= st_rc_wait;
            end else if (acq_periods == 6'd0) begin
              sample_enable <= 1'b0;
              state <= st_convert;
            end else begin
              state <= st_acquire;
            end
          end
        end
        st_rc_wait: begin
          // one instruction time lets the core settle before sampling ends
          if (tick_cnt == instr_cycles[15:0] - 16'h0001) begin
            tick_cnt <= 16'h0000;
            if (acq_periods == 6'd0) begin
              sample_enable <= 1'b0;
              state <= st_convert;
            end else begin
              state <= st_acquire;
            end
          end
        end
        st_acquire: begin
          if (acq_periods == 6'd0 || (bit_tick && period_cnt == acq_periods - 6'd1)) begin
            period_cnt <= 6'd0;
            tick_cnt <= 16'h0000;
            sample_enable <= 1'b0;
            state <= st_convert;
          end else if (bit_tick) begin
            period_cnt <= period_cnt + 6'd1;
          end
        end
        st_convert: begin
          if (finish) begin
            go <= 1'b0;
            state <= st_idle;
          end else if (bit_tick) begin
            period_cnt <= period_cnt + 6'd1;
          end
        end
        default: state <= st_idle;
      endcase
      if (!converter_power_on) begin
        go <= 1'b0;
        sample_enable <= 1'b0;
        state <= st_idle;
      end
    end
  end

  // result bytes: no reset, written by software or at conversion end
  always @(posedge ref_clk) begin
    if (finish) begin
      if (result_justify_select) begin
        result_high_byte <= {6'h00, code[9:8]};
        result_low_byte <= code[7:0];
      end else begin
        result_high_byte <= code[9:2];
        result_low_byte <= {code[1:0], 6'h00};
      end
    end else if (access && write && address == {1'b0, `OFS_RESULT_HIGH}) begin
      result_high_byte <= writedata[7:0];
    end else if (access && write && address == `ADDR_RESULT_LOW) begin
      result_low_byte <= writedata[7:0];
    end
  end

  // control registers, interrupt and bus slave
  always @(posedge ref_clk) begin
    if (srst) begin
      converter_power_on <= 1'b0;
      input_channel_select <= 4'h0;
      reference_source_select <= 2'h0;
      result_justify_select <= 1'b0;
      acquisition_delay_select <= 3'h0;
      conversion_clock_select <= 3'h0;
      conversion_done_irq_flag <= 1'b0;
      irq_mask <= 1'b0;
      irq <= 1'b0;
      waitrequest <= 1'b1;
      bus_done <= 1'b0;
      readdata <= 32'h00000000;
    end else begin
      waitrequest <= ~access;
      bus_done <= access;
      irq <= conversion_done_irq_flag & irq_mask;
      if (access && write) begin
        case (address)
          {1'b0, `OFS_CONTROL_ZERO}: begin
            input_channel_select <= writedata[5:2];
            converter_power_on <= writedata[`BIT_POWER_ON];
          end
          {1'b0, `OFS_CONTROL_ONE}: reference_source_select <= writedata[5:4];
          {1'b0, `OFS_CONTROL_TWO}: begin
            result_justify_select <= writedata[`BIT_JUSTIFY];
            acquisition_delay_select <= writedata[5:3];
            conversion_clock_select <= writedata[2:0];
          end
          `ADDR_IRQ_MASK: irq_mask <= writedata[0];
          default: ;
        endcase
      end
      // set wins over a write-one clear in the same cycle
      if (finish)
        conversion_done_irq_flag <= 1'b1;
      else if (access && write && address == `ADDR_IRQ_STATUS && writedata[0])
        conversion_done_irq_flag <= 1'b0;
      if (access && read) begin
        case (address)
          {1'b0, `OFS_CONTROL_ZERO}: readdata <= {26'h0, input_channel_select, go, converter_power_on};
          {1'b0, `OFS_CONTROL_ONE}: readdata <= {26'h0, reference_source_select, 4'h0};
          {1'b0, `OFS_CONTROL_TWO}: readdata <= {24'h0, result_justify_select, 1'b0,
                                                 acquisition_delay_select, conversion_clock_select};
          {1'b0, `OFS_RESULT_HIGH}: readdata <= {24'h0, result_high_byte};
          `ADDR_RESULT_LOW: readdata <= {24'h0, result_low_byte};
          `ADDR_IRQ_STATUS: readdata <= {31'h0, conversion_done_irq_flag};
          `ADDR_IRQ_MASK: readdata <= {31'h0, irq_mask};
          default: readdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ---- adc_result_map.vh ----
// register map, field positions and timing counts of the converter result block
// Overview of operation
// - left format: result 9..2 to high byte
// - left format: result 1..0 to low 7..6
// - right format: result 9..8 to high 1..0
// - right format: result 7..0 to low byte
// - result bytes writable, no reset value
// - acquisition interval precedes conversion start unless the acquisition code is 0
// - each result is 10-bit unsigned code
// - go bit starts, stays set, self-clears
// - acquisition field selects 0..20 bit periods
// - rc clock delays start one instruction
`ifndef ADC_RESULT_MAP_VH
`define ADC_RESULT_MAP_VH
`define OFS_CONTROL_ZERO 4'h0
`define OFS_CONTROL_ONE 4'h4
`define OFS_CONTROL_TWO 4'h8
`define OFS_RESULT_HIGH 4'hc
`define ADDR_RESULT_LOW 5'h10
`define ADDR_IRQ_STATUS 5'h14
`define ADDR_IRQ_MASK 5'h18
`define BIT_POWER_ON 0
`define BIT_GO 1
`define BIT_JUSTIFY 7
`define CONV_BITS 10
`define INSTR_CYCLES 4
`define BIT_PERIOD_CYCLES 16
`define RC_BIT_PERIOD_CYCLES 66
`endif

// ---- adc_result_sva.sv ----
// assertion checker for the converter result block
module adc_result_sva (
  input wire ref_clk,
  input wire srst,
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire irq,
  input wire sample_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  answer_one_a: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("late answer");
  wait_short_a: assert property ($fell(waitrequest) |=> waitrequest) else $error("long answer");
  wait_cause_a: assert property (!waitrequest |-> $past(read || write)) else $error("answer without request");
  upper_zero_a: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0) else $error("wide data");
  unmapped_zero_a: assert property (read && !waitrequest && address > 5'h18 |-> readdata == 32'h0)
    else $error("unmapped data");
  read_hold_a: assert property (!$stable(readdata) |-> $past(read)) else $error("data moved");
  irq_done_a: assert property ($rose(irq) |-> !sample_enable) else $error("irq while acquiring");
  acq_start_a: assert property ($rose(sample_enable) |-> $past(write, 1) || $past(write, 2))
    else $error("acquire without go");
endmodule
bind adc_result_format_and_acquire adc_result_sva chk (.ref_clk(ref_clk), .srst(srst), .address(address),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .sample_enable(sample_enable));

// ---- analog_source.sv ----
// analog input model: the held code is valid only once acquisition has ended
module analog_source (
  input wire ref_clk,
  input wire sample_enable,
  input wire [9:0] level,
  output logic [9:0] conversion_result
);
  timeunit 1ns;
  timeprecision 1ps;
  initial conversion_result = 10'h0;
  // garbage while the capacitor still charges, so an early sample is caught
  always @(posedge ref_clk)
    if (sample_enable) conversion_result <= ~conversion_result;
    else conversion_result <= level;
endmodule

// ---- testbench.sv ----
// bench: register access, result format, acquisition timing and interrupt
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, srst = 1, read = 0, write = 0, waitrequest, irq, sample_enable, fmt;
  logic [4:0] address = 0;
  logic [31:0] writedata = 0, readdata, rd;
  logic [3:0] input_channel_select, ch;
  logic [1:0] reference_source_select;
  logic [9:0] conversion_result, level = 0;
  logic [2:0] acq, cs;
  int n_mismatch = 0, samples_checked = 0, acq_len = 0, seed;
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (sample_enable === 1'b1) acq_len <= acq_len + 1;
  adc_result_format_and_acquire #(.bit_period(2), .rc_bit_period(3), .instr_cycles(2)) DUT (.ref_clk(ref_clk),
    .srst(srst), .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .input_channel_select(input_channel_select),
    .reference_source_select(reference_source_select), .sample_enable(sample_enable),
    .conversion_result(conversion_result));
  analog_source src (.ref_clk(ref_clk), .sample_enable(sample_enable), .level(level),
    .conversion_result(conversion_result));
  task automatic print_verdict();
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 0;
    write <= 0;
    @(posedge ref_clk);
  endtask
  // acquisition cycles the counter should see, in the scaled-down clocks
  function automatic int acq_exp(logic [2:0] a, logic [2:0] s);
    int conversion_bit_period[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    return (s == 3'h3 || s == 3'h7) ? conversion_bit_period[a] * 3 + 2 : conversion_bit_period[a] * 2;
  endfunction
  initial begin
    seed = $urandom(32'h2f00);
    repeat (16) @(posedge ref_clk);
    srst <= 0;
    @(posedge ref_clk);
    bus(1, 5'h18, 32'h1);
    for (int i = 0; i < 12; i++) begin
      fmt = i[0];
      acq = i < 8 ? i[2:0] : 3'($urandom);
      cs = i < 8 ? 3'(7 - i) : 3'($urandom);
      ch = 4'($urandom);
      level <= i == 1 ? 10'h3ff : i == 2 ? 10'h0 : 10'($urandom);
      bus(1, 5'h08, {24'h0, fmt, 1'b0, acq, cs});
      bus(1, 5'h04, {26'h0, ch[1:0], 4'h0});
      cmp(reference_source_select, ch[1:0]);
      bus(1, 5'h00, {26'h0, ch, 2'b01});
      acq_len = 0;
      bus(1, 5'h00, {26'h0, ch, 2'b11});
      do bus(0, 5'h00, 32'h0); while (rd[1] === 1'b1);
      cmp(acq_len, acq_exp(acq, cs));
      cmp(input_channel_select, ch);
      bus(0, 5'h0c, 32'h0);
      cmp(rd & (fmt ? 32'h03 : 32'hff), fmt ? level[9:8] : level[9:2]);
      bus(0, 5'h10, 32'h0);
      cmp(rd & (fmt ? 32'hff : 32'hc0), fmt ? level[7:0] : {level[1:0], 6'h0});
      cmp(irq, 1'b1);
      bus(0, 5'h14, 32'h0);
      cmp(rd, 32'h1);
      bus(1, 5'h14, 32'h1);
      cmp(irq, 1'b0);
    end
    bus(1, 5'h0c, 32'h5a);
    bus(0, 5'h0c, 32'h0);
    cmp(rd, 32'h5a);
    bus(0, 5'h1c, 32'h0);
    cmp(rd, 32'h0);
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule
